// ---- psc_board_model.sv ----
// Board strap wiring: each strap input tied to one stream output or to a supply rail.
`timescale 1ns/100ps
module psc_board_model
    import psc_pkg::*;
(
    input  wire logic [11:0] strap_src,
    input  psc_stream_s      strap_stream,
    output logic [3:0]       strap_in
);
    // ************************************************************
    // Source selection, coded like the decoded value it yields except code 5, which gives ground
    // ************************************************************
    function automatic logic pick(input logic [2:0] src, input psc_stream_s s);
        case (src)
            3'h1: pick = s.indicator_outputs[0];
            3'h2: pick = s.indicator_outputs[1];
            3'h3: pick = s.indicator_outputs[2];
            3'h4: pick = s.crs;
            3'h6: pick = s.col;
            3'h7: pick = 1'b1;
            default: pick = 1'b0;
        endcase
    endfunction : pick
    // Every strap is always tied to a defined level, so none floats.
    assign strap_in[0] = pick(strap_src[2:0], strap_stream);
    assign strap_in[1] = pick(strap_src[5:3], strap_stream);
    assign strap_in[2] = pick(strap_src[8:6], strap_stream);
    assign strap_in[3] = pick(strap_src[11:9], strap_stream);
endmodule : psc_board_model

// ---- psc_checker.sv ----
// Concurrent checks on the ports of the strap loader and hold control.
`timescale 1ns/100ps
module psc_checker
    import psc_pkg::*;
#(
    parameter int PHASE_CYC = PSC_PHASE_CYC
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        hardware_rst_pin_n,
    input wire logic        low_power_hold_n,
    input psc_stream_s      strap_stream,
    input psc_cfg_s         cfg,
    input wire logic [1:0]  xover_ctrl,
    input wire logic [1:0]  mac_if_mode,
    input wire logic        fiber_sel,
    input wire logic        device_active,
    input wire logic        low_power
);
    `include "psc_tb_defs.svh"
    // ************************************************************
    // Port relations
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_HOLD_REFUSE: assert property (psel && penable && low_power |-> pslverr && prdata == 32'h0)
        else $error("register access served in low power");
    AST_RST_WINS: assert property (!hardware_rst_pin_n [*3] |=> !low_power && !device_active)
        else $error("reset pin did not take priority");
    AST_HOLD_ENTER: assert property ((hardware_rst_pin_n && !low_power_hold_n && device_active) [*3] |=> low_power)
        else $error("hold pin did not enter low power");
    AST_HOLD_EXIT: assert property ((hardware_rst_pin_n && low_power_hold_n && low_power) [*3] |=> device_active)
        else $error("hold release did not resume operation");
    AST_ACCESS_OK: assert property (psel && penable && device_active && paddr == PSC_XOVER_CTRL_OFS |-> pready && !pslverr)
        else $error("access refused in normal operation");
    AST_STREAM_IDLE: assert property (device_active && $past(device_active) |-> strap_stream == '0)
        else $error("strap stream driven outside initialization");
    AST_CFG_HOLD: assert property ((device_active || low_power) && ($past(device_active) || $past(low_power)) |-> $stable(cfg))
        else $error("latched configuration changed");
    AST_XOVER_LOAD: assert property ($rose(device_active) && !$past(low_power) |-> xover_ctrl == {2{cfg.auto_swap_default}})
        else $error("crossover default does not follow swap strap");
    AST_MODE_LOAD: assert property ($rose(device_active) && !$past(low_power) |-> {mac_if_mode, fiber_sel} == psc_exp_load(cfg.mode))
        else $error("mode defaults wrong");
    CVR_HOLD: cover property ($rose(low_power));
    CVR_LOAD: cover property ($rose(device_active) && !$past(low_power));
    CVR_REFUSE: cover property (psel && penable && pslverr);
endmodule : psc_checker

bind psc_top psc_checker #(.PHASE_CYC(PHASE_CYC)) psc_checker_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hardware_rst_pin_n(hardware_rst_pin_n),
    .low_power_hold_n(low_power_hold_n), .strap_stream(strap_stream), .cfg(cfg), .xover_ctrl(xover_ctrl),
    .mac_if_mode(mac_if_mode), .fiber_sel(fiber_sel), .device_active(device_active), .low_power(low_power)
);

// ---- psc_pkg.sv ----
// Shared constants, types and decode functions for the strap loader and hold control.
package psc_pkg;

    // ************************************************************
    // Register map and field layout
    // ************************************************************
    localparam logic [7:0] PSC_STRAP_STAT_OFS = 8'h00;
    localparam logic [7:0] PSC_XOVER_CTRL_OFS = 8'h04;
    localparam logic [7:0] PSC_MAC_CFG_OFS    = 8'h08;
    localparam logic [7:0] PSC_STATE_STAT_OFS = 8'h0c;

    localparam int PSC_STAT_ADDR_LSB  = 0;
    localparam int PSC_STAT_SWAP_BIT  = 5;
    localparam int PSC_STAT_MODE_LSB  = 8;
    localparam int PSC_STAT_FIBER_BIT = 12;
    localparam int PSC_STAT_RSVD_BIT  = 16;
    localparam int PSC_XOVER_LSB      = 4;
    localparam int PSC_MACMODE_LSB    = 10;
    localparam int PSC_FIBER_BIT      = 3;

    localparam logic [1:0]  PSC_XOVER_MDI   = 2'h0;
    localparam logic [1:0]  PSC_XOVER_AUTO  = 2'h3;
    localparam logic [31:0] PSC_REG_RESET   = 32'h0000_0000;

    // ************************************************************
    // Strap stream codes, one bit per initialization phase
    // ************************************************************
    localparam int         PSC_PHASES   = 3;
    localparam logic [2:0] PSC_CODE_LED0 = 3'h1;
    localparam logic [2:0] PSC_CODE_LED1 = 3'h2;
    localparam logic [2:0] PSC_CODE_LED2 = 3'h3;
    localparam logic [2:0] PSC_CODE_CRS  = 3'h4;
    localparam logic [2:0] PSC_CODE_COL  = 3'h6;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int PSC_CLK_HZ      = 10_000_000;
    localparam int PSC_PHASE_NS    = 1000;
    localparam int PSC_PHASE_CYC   = (PSC_PHASE_NS * (PSC_CLK_HZ / 1_000_000) + 999) / 1000;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        ST_INIT = 3'h1,
        ST_RUN  = 3'h2,
        ST_HOLD = 3'h4
    } psc_state_e;

    typedef struct packed {
        logic [2:0] indicator_outputs;
        logic       crs;
        logic       col;
    } psc_stream_s;

    typedef struct packed {
        logic [4:0] station_addr;
        logic       auto_swap_default;
        logic [2:0] mode;
        logic       reserved_seen;
    } psc_cfg_s;

    function automatic logic [1:0] psc_mac_mode(input logic [2:0] mode);
        unique case (mode)
            3'h0, 3'h2: psc_mac_mode = 2'h0;
            3'h1, 3'h7: psc_mac_mode = 2'h1;
            3'h3, 3'h4: psc_mac_mode = 2'h2;
            default:    psc_mac_mode = 2'h3;
        endcase
    endfunction : psc_mac_mode

    function automatic logic psc_is_fiber(input logic [2:0] mode);
        psc_is_fiber = (mode == 3'h2) || (mode == 3'h4) || (mode == 3'h7);
    endfunction : psc_is_fiber

endpackage : psc_pkg

// ---- psc_strap_capture.sv ----
// Drives the initialization bit stream and samples the four strap inputs per phase.
`timescale 1ns/100ps
module psc_strap_capture
    import psc_pkg::*;
#(
    parameter int PHASE_CYC = PSC_PHASE_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        active,
    input  wire logic [3:0]  strap_sync,
    output psc_stream_s      stream,
    output logic [2:0]       code3,
    output logic [5:0]       code_lo,
    output logic             rsvd_lo,
    output logic             pass_done
);
    logic [15:0] cyc;
    logic [1:0]  phase;
    logic [2:0]  samp [4];
    logic        phase_end;
    psc_stream_s next_stream;

    assign phase_end = (cyc == 16'(PHASE_CYC - 1));

    // Phase k puts bit k of each source code on its output.
    assign next_stream.indicator_outputs = active ? {PSC_CODE_LED2[phase], PSC_CODE_LED1[phase],
                                                     PSC_CODE_LED0[phase]} : 3'h0; // R08
    assign next_stream.crs = active & PSC_CODE_CRS[phase]; // R08
    assign next_stream.col = active & PSC_CODE_COL[phase]; // R08

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc       <= 16'h0;
            phase     <= 2'h0;
            stream    <= '0;
            pass_done <= 1'b0;
            code3     <= 3'h0;
            code_lo   <= 6'h0;
            rsvd_lo   <= 1'b0;
            for (int i = 0; i < 4; i++) samp[i] <= 3'h0;
        end else if (ce) begin
            stream <= next_stream;
            if (!active) begin
                cyc       <= 16'h0;
                phase     <= 2'h0;
                pass_done <= 1'b0;
            end else if (phase_end) begin
                cyc <= 16'h0;
                for (int i = 0; i < 4; i++) samp[i][phase] <= strap_sync[i];
                if (phase == 2'(PSC_PHASES - 1)) begin
                    phase     <= 2'h0;
                    pass_done <= 1'b1;
                    code3     <= {strap_sync[3], samp[3][1:0]}; // R10
                    code_lo   <= {samp[2][1:0], samp[1][1:0], samp[0][1:0]}; // R10
                    // Only ground, indicator0, indicator1 and the rail give bit 2 equal to bits 1 and 0 anded.
                    rsvd_lo   <= |(strap_sync[2:0] ^ {&samp[2][1:0], &samp[1][1:0], &samp[0][1:0]}); // R10
                end else begin
                    phase <= phase + 2'h1;
                end
            end else begin
                cyc <= cyc + 16'h1;
            end
        end
    end
endmodule : psc_strap_capture

// ---- psc_sync.sv ----
// Two-stage synchronizer for asynchronous pin levels.
`timescale 1ns/100ps
module psc_sync #(
    parameter int            WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= INIT;
            q    <= INIT;
        end else if (ce) begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : psc_sync

// ---- psc_tb_defs.svh ----
// Expected MAC mode and fiber defaults for each mode code, packed as {mac mode, fiber}.
function automatic logic [2:0] psc_exp_load(input logic [2:0] m);
    case (m)
        3'h0: psc_exp_load = 3'h0;
        3'h1: psc_exp_load = 3'h2;
        3'h2: psc_exp_load = 3'h1;
        3'h3: psc_exp_load = 3'h4;
        3'h4: psc_exp_load = 3'h5;
        3'h7: psc_exp_load = 3'h3;
        default: psc_exp_load = 3'h6;
    endcase
endfunction : psc_exp_load

// ---- psc_top.sv ----
// Strap configuration loader and low-power hold control with an APB register port.
`timescale 1ns/100ps

// Behaviour
// R01: While the hold pin is low the block enters low power and refuses every register access.
// R02: A hardware reset held together with the hold pin wins, and the hold request is ignored.
// R03: After supplies return the system must apply hardware reset before normal operation is expected.
// R04: If the reference clock stopped, the system restarts it and then applies hardware reset.
// R05: With supplies and clock present, low power is entered and left by the hold pin alone.
// R06: The reference clock may only stop 1 ms after hold assertion and restart no later than hold release.
// R07: Every register keeps its contents across entry to, stay in, and exit from low power.
// R08: During initialization each indicator, carrier and collision output drives a distinct bit stream.
// R09: Strap values are captured at the release of hardware reset and used as configuration from then on.
// R10: Strap 3 decodes three bits from its source, straps 2 to 0 decode two bits.
// R11: The board ties no indicator2, carrier or collision output to straps 2 to 0.
// R12: No strap input is left unconnected.
// R13: Straps 0 and 1 give address bits 3:0, strap 2 gives address bit 4 and the swap default, strap 3 the mode.
// R14: The swap default sets the reset value of the crossover field, 1 meaning automatic swapping.
// R15: The mode code selects copper or fiber and the MAC interface type.
// R16: The mode code loads the MAC mode and fiber defaults.
// R17: The latched configuration stays fixed until the next hardware reset release.
module psc_top
    import psc_pkg::*;
#(
    parameter int PHASE_CYC = PSC_PHASE_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        hardware_rst_pin_n,
    input  wire logic        low_power_hold_n,
    input  wire logic [3:0]  strap_in,
    output psc_stream_s      strap_stream,
    output psc_cfg_s         cfg,
    output logic [1:0]       xover_ctrl,
    output logic [1:0]       mac_if_mode,
    output logic             fiber_sel,
    output logic             device_active,
    output logic             low_power
);

    // ************************************************************
    // Pin synchronizers
    // ************************************************************
    logic       rst_pin_n_s;
    logic       hold_n_s;
    logic [3:0] strap_s;

    psc_sync #(
        .WIDTH (2),
        .INIT  (2'h1)
    ) u_sync_ctl (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .d       ({hardware_rst_pin_n, low_power_hold_n}),
        .q       ({rst_pin_n_s, hold_n_s})
    );

    psc_sync #(
        .WIDTH (4),
        .INIT  (4'h0)
    ) u_sync_strap (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .d       (strap_in),
        .q       (strap_s)
    );

    // ************************************************************
    // Operating state
    // ************************************************************
    psc_state_e state;
    psc_state_e next_state;
    logic       leave_init;

    // Hardware reset is checked first so a simultaneous hold request is ignored.
    always_comb begin
        next_state = state;
        unique case (state)
            ST_INIT: begin
                if (rst_pin_n_s) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!rst_pin_n_s) begin
                    next_state = ST_INIT; // R02
                end else if (!hold_n_s) begin
                    next_state = ST_HOLD; // R01
                end
            end
            ST_HOLD: begin
                if (!rst_pin_n_s) begin
                    next_state = ST_INIT; // R02
                end else if (hold_n_s) begin
                    next_state = ST_RUN; // R05
                end
            end
            default: next_state = ST_INIT;
        endcase
    end

    assign leave_init = (state == ST_INIT) && rst_pin_n_s; // R09

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_INIT;
        end else if (ce) begin
            state <= next_state;
        end
    end

    assign device_active = (state == ST_RUN);
    assign low_power     = (state == ST_HOLD); // R01

    // ************************************************************
    // Strap stream and capture
    // ************************************************************
    logic [2:0] code3;
    logic [5:0] code_lo;
    logic       rsvd_lo;
    logic       pass_done;

    psc_strap_capture #(
        .PHASE_CYC (PHASE_CYC)
    ) u_capture (
        .pclk       (pclk),
        .presetn    (presetn),
        .ce         (ce),
        .active     (state == ST_INIT),
        .strap_sync (strap_s),
        .stream     (strap_stream),
        .code3      (code3),
        .code_lo    (code_lo),
        .rsvd_lo    (rsvd_lo),
        .pass_done  (pass_done)
    );

    // ************************************************************
    // Configuration latch
    // ************************************************************
    psc_cfg_s next_cfg;

    assign next_cfg.station_addr      = {code_lo[4], code_lo[3:2], code_lo[1:0]}; // R13
    assign next_cfg.auto_swap_default = code_lo[5]; // R13
    assign next_cfg.mode              = code3; // R13
    assign next_cfg.reserved_seen     = rsvd_lo | ~pass_done;

    // Only the reset release loads the latch; strap or hold activity later has no effect.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= '0;
        end else if (ce && leave_init) begin
            cfg <= next_cfg; // R17
        end
    end

    // ************************************************************
    // APB decode
    // ************************************************************
    logic sel_stat;
    logic sel_xover;
    logic sel_mac;
    logic sel_state;
    logic mapped;
    logic writable;
    logic refuse;
    logic setup_ph;
    logic access_ph;
    logic wr_ok;

    assign sel_stat  = (paddr == PSC_STRAP_STAT_OFS);
    assign sel_xover = (paddr == PSC_XOVER_CTRL_OFS);
    assign sel_mac   = (paddr == PSC_MAC_CFG_OFS);
    assign sel_state = (paddr == PSC_STATE_STAT_OFS);
    assign mapped    = sel_stat | sel_xover | sel_mac | sel_state;
    assign writable  = sel_xover | sel_mac;
    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;

    // Outside normal operation the register file does not answer with data.
    assign refuse  = ~device_active | ~mapped | (pwrite & ~writable); // R01
    assign pready  = 1'b1;
    assign pslverr = access_ph & refuse;
    assign wr_ok   = ce & access_ph & pwrite & ~refuse;

    // ************************************************************
    // Registers
    // ************************************************************
    logic [31:0] stat_word;
    logic [31:0] xover_word;
    logic [31:0] mac_word;
    logic [31:0] state_word;
    logic [31:0] next_rdata;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xover_ctrl <= PSC_XOVER_MDI;
        end else if (ce) begin
            if (leave_init) begin
                xover_ctrl <= next_cfg.auto_swap_default ? PSC_XOVER_AUTO : PSC_XOVER_MDI; // R14
            end else if (wr_ok && sel_xover) begin
                xover_ctrl <= pwdata[PSC_XOVER_LSB +: 2];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mac_if_mode <= 2'h0;
            fiber_sel   <= 1'b0;
        end else if (ce) begin
            if (leave_init) begin
                mac_if_mode <= psc_mac_mode(next_cfg.mode); // R16
                fiber_sel   <= psc_is_fiber(next_cfg.mode); // R15
            end else if (wr_ok && sel_mac) begin
                mac_if_mode <= pwdata[PSC_MACMODE_LSB +: 2];
                fiber_sel   <= pwdata[PSC_FIBER_BIT];
            end
        end
    end
    // Nothing above is touched in ST_HOLD, so contents survive low power intact. R07

    always_comb begin
        stat_word = PSC_REG_RESET;
        stat_word[PSC_STAT_ADDR_LSB +: 5] = cfg.station_addr;
        stat_word[PSC_STAT_SWAP_BIT]      = cfg.auto_swap_default;
        stat_word[PSC_STAT_MODE_LSB +: 3] = cfg.mode;
        stat_word[PSC_STAT_FIBER_BIT]     = psc_is_fiber(cfg.mode);
        stat_word[PSC_STAT_RSVD_BIT]      = cfg.reserved_seen;
    end

    always_comb begin
        xover_word = PSC_REG_RESET;
        xover_word[PSC_XOVER_LSB +: 2] = xover_ctrl;
    end

    always_comb begin
        mac_word = PSC_REG_RESET;
        mac_word[PSC_MACMODE_LSB +: 2] = mac_if_mode;
        mac_word[PSC_FIBER_BIT]        = fiber_sel;
    end

    always_comb begin
        state_word = PSC_REG_RESET;
        state_word[2:0] = state;
    end

    always_comb begin
        next_rdata = 32'h0;
        if (!refuse) begin
            unique case (1'b1)
                sel_stat:  next_rdata = stat_word;
                sel_xover: next_rdata = xover_word;
                sel_mac:   next_rdata = mac_word;
                sel_state: next_rdata = state_word;
                default:   next_rdata = 32'h0;
            endcase
        end
    end

    // Read data is taken in the setup cycle so it stands from a flop during access.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (ce && setup_ph) begin
            prdata <= pwrite ? 32'h0 : next_rdata;
        end
    end

endmodule : psc_top

// ---- psc_top_test.sv ----
// Self-checking bench for the strap loader and hold control.
`timescale 1ns/100ps
module psc_top_test
    import psc_pkg::*;
();
    `include "psc_tb_defs.svh"
    localparam int PH = 4;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        hardware_rst_pin_n = 1'b0;
    logic        low_power_hold_n = 1'b1;
    logic [11:0] strap_src = 12'h000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [3:0]  strap_in;
    psc_stream_s strap_stream;
    psc_cfg_s    cfg;
    logic [1:0]  xover_ctrl;
    logic [1:0]  mac_if_mode;
    logic        fiber_sel;
    logic        device_active;
    logic        low_power;
    int          num_errors = 0;
    int          checks_done = 0;
    int          cyc = 0;

    psc_top #(.PHASE_CYC(PH)) psc_top_i (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hardware_rst_pin_n(hardware_rst_pin_n), .low_power_hold_n(low_power_hold_n), .strap_in(strap_in),
        .strap_stream(strap_stream), .cfg(cfg), .xover_ctrl(xover_ctrl), .mac_if_mode(mac_if_mode),
        .fiber_sel(fiber_sel), .device_active(device_active), .low_power(low_power));
    psc_board_model psc_board_model_i (.strap_src(strap_src), .strap_stream(strap_stream), .strap_in(strap_in));

    initial forever #50 pclk = ~pclk;

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // A hang anywhere ends the run as a failure instead of running forever.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_active(input logic want_hold);
        for (int i = 0; i < 40 && (want_hold ? low_power : device_active) !== 1'b1; i++) @(posedge pclk);
    endtask : wait_active

    // Low straps see only ground, indicators 0 and 1, or the rail.
    function automatic logic [2:0] lo(input logic [1:0] v);
        lo = (v == 2'h3) ? 3'h7 : {1'b0, v};
    endfunction : lo

    task automatic pin_reset(input logic [11:0] src);
        @(posedge pclk);
        strap_src          <= src;
        hardware_rst_pin_n <= 1'b0;
        repeat (3 * PH + 12) @(posedge pclk);
        hardware_rst_pin_n <= 1'b1;
        wait_active(1'b0);
    endtask : pin_reset

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_config(input logic [2:0] s3, input logic [1:0] s2, input logic [1:0] s1, input logic [1:0] s0);
        logic [31:0] r;
        logic        e;
        logic [2:0]  ld;
        ld = psc_exp_load(s3);
        pin_reset({s3, lo(s2), lo(s1), lo(s0)});
        check(32'(device_active), 32'h1);
        check(32'(cfg.station_addr), 32'({s2[0], s1, s0}));
        check(32'(cfg.auto_swap_default), 32'(s2[1]));
        check(32'(cfg.mode), 32'(s3));
        check(32'(cfg.reserved_seen), 32'h0);
        check(32'(xover_ctrl), 32'(s2[1] ? PSC_XOVER_AUTO : PSC_XOVER_MDI));
        check(32'({mac_if_mode, fiber_sel}), 32'(ld));
        apb(1'b0, PSC_STRAP_STAT_OFS, 32'h0, r, e);
        check(32'(e), 32'h0);
        check(r, {16'h0, 3'h0, ld[0], 1'b0, s3, 2'h0, s2, s1, s0});
    endtask : t_config

    task automatic t_hold();
        logic [31:0] r;
        logic        e;
        psc_cfg_s    c;
        c = cfg;
        apb(1'b1, PSC_XOVER_CTRL_OFS, 32'h0000_0010, r, e);
        check(32'(e), 32'h0);
        apb(1'b1, PSC_MAC_CFG_OFS, 32'hffff_fff7, r, e);
        low_power_hold_n <= 1'b0;
        strap_src        <= ~strap_src;
        wait_active(1'b1);
        check(32'(low_power), 32'h1);
        apb(1'b0, PSC_XOVER_CTRL_OFS, 32'h0, r, e);
        check(32'(e), 32'h1);
        check(r, 32'h0);
        apb(1'b1, PSC_MAC_CFG_OFS, 32'h0, r, e);
        check(32'(e), 32'h1);
        low_power_hold_n <= 1'b1;
        wait_active(1'b0);
        check(32'(device_active), 32'h1);
        apb(1'b1, 8'h10, 32'hffff_ffff, r, e);
        check(32'(e), 32'h1);
        apb(1'b1, PSC_STRAP_STAT_OFS, 32'hffff_ffff, r, e);
        check(32'(e), 32'h1);
        apb(1'b0, PSC_XOVER_CTRL_OFS, 32'h0, r, e);
        check(r, 32'h0000_0010);
        apb(1'b0, PSC_MAC_CFG_OFS, 32'h0, r, e);
        check(r, 32'h0000_0c00);
        apb(1'b0, PSC_STATE_STAT_OFS, 32'h0, r, e);
        check(r, 32'h2);
        check(32'(cfg), 32'(c));
    endtask : t_hold

    task automatic t_rst_hold();
        logic [31:0] r;
        logic        e;
        @(posedge pclk);
        hardware_rst_pin_n <= 1'b0;
        low_power_hold_n   <= 1'b0;
        strap_src          <= {3'h6, 3'h7, 3'h1, 3'h2};
        repeat (3 * PH + 12) @(posedge pclk);
        check(32'({low_power, device_active}), 32'h0);
        apb(1'b0, PSC_STATE_STAT_OFS, 32'h0, r, e);
        check(32'(e), 32'h1);
        hardware_rst_pin_n <= 1'b1;
        wait_active(1'b1);
        check(32'(low_power), 32'h1);
        low_power_hold_n <= 1'b1;
        wait_active(1'b0);
        check(32'({cfg.mode, cfg.reserved_seen}), 32'({3'h6, 1'b0}));
        check(32'(cfg.station_addr), 32'h16);
    endtask : t_rst_hold

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int m = 0; m < 8; m++) begin
            if (m != 5) t_config(3'(m), 2'(m + 1), 2'(m), 2'(3 - m));
        end
        t_hold();
        t_rst_hold();
        finish_test();
    end
endmodule : psc_top_test
